// [hw/ssc_fifo.sv]
// ssc_fifo: word store with a run-time fill limit
// assumes: DEPTH a power of two; caller reads headData before pop
`timescale 1ns/1ps
module ssc_fifo import ssc_pkg::*; #(
  parameter int W     = 8,
  parameter int DEPTH = FIFO_DEPTH,
  localparam int CW   = $clog2(DEPTH + 1),
  localparam int AW   = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  // control
  input  wire logic          flush,
  input  wire logic [CW-1:0] limit,
  // write side
  input  wire logic          push,
  input  wire logic [W-1:0]  pushData,
  // read side
  input  wire logic          pop,
  output logic      [W-1:0]  headData,
  // fill state
  output logic      [CW-1:0] count,
  output logic               full,
  output logic               empty
);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  wire           doPush = push & ~full;
  wire           doPop  = pop & ~empty;

  // fill flags against the active limit
  assign full     = (count >= limit);
  assign empty    = (count == '0);
  assign headData = mem[rdPtr];

  ////////////////////////////////////////////////////////////////////////
  // storage array
  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtr] <= pushData;
    end
  end

  // pointers and occupancy
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= wrPtr + AW'(doPush);
      rdPtr <= rdPtr + AW'(doPop);
      count <= count + CW'(doPush) - CW'(doPop);
    end
  end

endmodule

// [hw/ssc_pkg.sv]
// ssc_pkg: shared constants of the serial port status and control block
// assumes: imported whole by every module of the block
package ssc_pkg;

  // register byte offsets on the register bus
  localparam logic [7:0] OFF_STAT     = 8'h00;
  localparam logic [7:0] OFF_DATA     = 8'h04;
  localparam logic [7:0] OFF_CTRL     = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h14;

  // status/control field positions
  localparam int BIT_EN     = 15;
  localparam int BIT_SIDL   = 13;
  localparam int BIT_BEC    = 8;
  localparam int BIT_SHIFT_REG_EMPTY_FLAG  = 7;
  localparam int BIT_ROV    = 6;
  localparam int BIT_RX_FIFO_EMPTY_FLAG = 5;
  localparam int BIT_INTERRUPT_CONDITION_SELECT  = 2;
  localparam int BIT_TBF    = 1;
  localparam int BIT_RBF    = 0;
  // mode register and interrupt register fields
  localparam int BIT_ENH    = 0;
  localparam int BIT_MSTR   = 1;
  localparam int IRQ_COND   = 0;
  localparam int IRQ_ROV    = 1;

  // interrupt condition select codes
  localparam logic [2:0] SIS_TXFULL  = 3'h7;
  localparam logic [2:0] SIS_TXEMPTY = 3'h6;
  localparam logic [2:0] SIS_SENT    = 3'h5;
  localparam logic [2:0] SIS_TXONE   = 3'h4;
  localparam logic [2:0] SIS_RXFULL  = 3'h3;
  localparam logic [2:0] SIS_RX3Q    = 3'h2;
  localparam logic [2:0] SIS_RXAVAIL = 3'h1;
  localparam logic [2:0] SIS_RXREAD  = 3'h0;

  // values after reset, bus responses, serial clock half period
  localparam logic [2:0] INTERRUPT_CONDITION_SELECT_RST    = 3'h0;
  localparam logic [1:0] IRQ_EN_RST   = 2'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam int         SCK_HALF_CYC = 4;
  localparam int         FIFO_DEPTH   = 8;

  // shifter states
  typedef enum logic [1:0] {SH_IDLE = 2'b01, SH_RUN = 2'b10} ssc_sh_e;

endpackage

// [hw/ssc_shifter.sv]
// ssc_shifter: serial shift register, master clock maker and slave edge finder
// assumes: pins come from outside and are synchronised here; mode 0 framing
`timescale 1ns/1ps
module ssc_shifter import ssc_pkg::*; #(
  parameter int W    = 8,
  parameter int HALF = SCK_HALF_CYC
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // control from the status logic
  input  wire logic         run,
  input  wire logic         master,
  input  wire logic         load,
  input  wire logic [W-1:0] loadData,
  output logic              busy,
  output logic              rxDone,
  output logic              sent,
  output logic      [W-1:0] rxData,
  // serial pins
  input  wire logic         serialClockIn,
  input  wire logic         serialIn,
  input  wire logic         slaveSelectIn,
  output logic              serialClockOut,
  output logic              serialClockOe,
  output logic              serialOut,
  output logic              serialOutOe,
  output logic              slaveSelectOut,
  output logic              slaveSelectOe
);

  ssc_sh_e      st;
  logic [2:0]   syncA;
  logic [2:0]   syncB;
  logic         sckPrev;
  logic [7:0]   divCnt;
  logic [7:0]   bitCnt;
  logic [W-1:0] txSr;
  logic [W-1:0] rxSr;

  // synchronised pins and derived edges
  wire sckS  = syncB[2];
  wire sdiS  = syncB[1];
  wire ssS   = syncB[0];
  wire tick  = (divCnt == 8'(HALF - 1));
  wire sRise = sckS & ~sckPrev & ~ssS;
  wire sFall = ~sckS & sckPrev & ~ssS;
  wire rise  = master ? (tick & ~serialClockOut) : sRise;
  wire fall  = master ? (tick & serialClockOut) : sFall;
  wire last  = (bitCnt == 8'(W - 1));
  assign busy = (st == SH_RUN);

  ////////////////////////////////////////////////////////////////////////
  // two-stage pin synchroniser, edge history on the second stage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA   <= 3'h1;
      syncB   <= 3'h1;
      sckPrev <= 1'b0;
    end else begin
      syncA   <= {serialClockIn, serialIn, slaveSelectIn};
      syncB   <= syncA;
      sckPrev <= syncB[2];
    end
  end

  // shift engine
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= SH_IDLE;
      {rxDone, sent, serialClockOut, serialOut} <= 4'h0;
      {serialClockOe, serialOutOe, slaveSelectOe} <= 3'h0;
      slaveSelectOut <= 1'b1;
      {divCnt, bitCnt} <= 16'h0;
      {txSr, rxSr, rxData} <= '0;
    end else begin
      rxDone        <= 1'b0;
      sent          <= 1'b0;
      serialClockOe <= run & master;
      slaveSelectOe <= run & master;
      serialOutOe   <= run & (master | ~ssS);
      if (!run) begin
        st             <= SH_IDLE;
        slaveSelectOut <= 1'b1;
        serialClockOut <= 1'b0;
        divCnt         <= 8'h0;
      end else begin
        case (st)
          SH_IDLE: if (load) begin
            st             <= SH_RUN;
            txSr           <= loadData;
            serialOut      <= loadData[W-1];
            bitCnt         <= 8'h0;
            divCnt         <= 8'h0;
            slaveSelectOut <= ~master;
          end
          SH_RUN: begin
            divCnt <= tick ? 8'h0 : divCnt + 8'h1;
            if (rise) begin
              rxSr           <= {rxSr[W-2:0], sdiS};
              serialClockOut <= master;
              if (last) begin
                rxDone <= 1'b1;
                rxData <= {rxSr[W-2:0], sdiS};
              end
            end
            if (fall) begin
              serialClockOut <= 1'b0;
              if (last) begin
                st             <= SH_IDLE;
                sent           <= 1'b1;
                slaveSelectOut <= 1'b1;
              end else begin
                bitCnt    <= bitCnt + 8'h1;
                txSr      <= txSr << 1;
                serialOut <= txSr[W-2];
              end
            end
          end
          default: st <= SH_IDLE;
        endcase
      end
    end
  end

endmodule

// [hw/ssc_top.sv]
// ssc_top: serial port status/control registers, buffers and interrupt
// assumes: AXI4-Lite master on ref_clk; deviceIdle from the same clock
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module ssc_top import ssc_pkg::*; #(
  parameter int W     = 8,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int HALF  = SCK_HALF_CYC
) (
  // clock, reset, power state
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        deviceIdle,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  // interrupt
  output logic             irq,
  // serial pins
  input  wire logic        serialClockIn,
  output logic             serialClockOut,
  output logic             serialClockOe,
  input  wire logic        serialIn,
  output logic             serialOut,
  output logic             serialOutOe,
  input  wire logic        slaveSelectIn,
  output logic             slaveSelectOut,
  output logic             slaveSelectOe
);

  localparam int CW = $clog2(DEPTH + 1);

  // control and status state
  logic         portEnable;
  logic         idleStop;
  logic [2:0]   interrupt_condition_select;
  logic         rov;
  logic         enh;
  logic         master;
  logic [1:0]   irqStat;
  logic [1:0]   irqEn;
  logic [7:0]   awAddr;
  logic [31:0]  wData;
  logic [3:0]   wStrb;
  logic         loadD;
  logic         readD;
  logic         txFullD;
  // buffer and shifter wires
  logic [W-1:0] txHead;
  logic [W-1:0] rxHead;
  logic [W-1:0] rxWord;
  logic [CW-1:0] txCount;
  logic [CW-1:0] rxCount;
  logic         txFull;
  logic         txEmpty;
  logic         rxFull;
  logic         rxEmpty;
  logic         shBusy;
  logic         rxDone;
  logic         shSent;

  ////////////////////////////////////////////////////////////////////////
  // run gating and buffer limits
  wire          run     = portEnable & ~(idleStop & deviceIdle);
  wire [CW-1:0] limit   = enh ? CW'(DEPTH) : CW'(1);
  wire          shLoad  = run & ~shBusy & ~txEmpty;
  wire          rxPush  = rxDone & ~rxFull;
  wire          rxOver  = rxDone & rxFull;
  wire [CW-1:0] becSrc  = master ? txCount : rxCount;
  wire [2:0]    bec     = enh ? ((becSrc > CW'(7)) ? 3'h7 : becSrc[2:0]) : 3'h0;

  // bus write decode
  wire        doWrite = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire        wrStat  = doWrite & (awAddr == OFF_STAT);
  wire        wrData  = doWrite & (awAddr == OFF_DATA);
  wire        wrCtrl  = doWrite & (awAddr == OFF_CTRL);
  wire        wrClr   = doWrite & (awAddr == OFF_IRQ_CLR);
  wire        wrIrqEn = doWrite & (awAddr == OFF_IRQ_EN);
  wire        wrHit   = wrStat | wrData | wrCtrl | wrClr | wrIrqEn | (awAddr == OFF_IRQ_STAT);
  wire        txPush  = wrData & portEnable & wStrb[0] & ~txFull;
  wire        rovClr  = wrStat & wStrb[0] & ~wData[BIT_ROV];

  // bus read decode, reading data pops the receive store
  wire        arHs    = s_axi_arvalid & s_axi_arready;
  wire        rdData  = arHs & (s_axi_araddr == OFF_DATA);
  wire        rxPop   = rdData & ~rxEmpty;
  wire [15:0] statRd  = {portEnable, 1'b0, idleStop, 2'b00, bec, ~shBusy, rov, rxEmpty,
                         interrupt_condition_select, txFull, rxFull};
  wire [31:0] rdMux   = (s_axi_araddr == OFF_STAT)     ? {16'h0, statRd} :
                        (s_axi_araddr == OFF_DATA)     ? 32'(rxHead) :
                        (s_axi_araddr == OFF_CTRL)     ? {30'h0, master, enh} :
                        (s_axi_araddr == OFF_IRQ_STAT) ? {30'h0, irqStat} :
                        (s_axi_araddr == OFF_IRQ_EN)   ? {30'h0, irqEn} : 32'h0;
  wire        rdHit   = (s_axi_araddr == OFF_STAT) | (s_axi_araddr == OFF_DATA) |
                        (s_axi_araddr == OFF_CTRL) | (s_axi_araddr == OFF_IRQ_STAT) |
                        (s_axi_araddr == OFF_IRQ_EN);

  // interrupt condition per select code
  wire txOne   = (txCount == limit - CW'(1));
  wire condEnh = (interrupt_condition_select == SIS_TXFULL  & txFull & ~txFullD) |
                 (interrupt_condition_select == SIS_TXONE   & loadD & txOne) |
                 (interrupt_condition_select == SIS_TXEMPTY & loadD & txEmpty) |
                 (interrupt_condition_select == SIS_SENT    & shSent) |
                 (interrupt_condition_select == SIS_RXFULL  & rxFull) |
                 (interrupt_condition_select == SIS_RX3Q    & (rxCount >= CW'((DEPTH * 3) / 4))) |
                 (interrupt_condition_select == SIS_RXAVAIL & ~rxEmpty) |
                 (interrupt_condition_select == SIS_RXREAD  & readD & rxEmpty);
  wire cond    = enh ? condEnh : rxPush;
  wire [1:0] irqSet = {rxOver, cond};
  wire [1:0] irqClr = wrClr & wStrb[0] ? wData[1:0] : 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // transmit and receive stores
  ssc_fifo #(.W(W), .DEPTH(DEPTH)) u_tx (
    .ref_clk(ref_clk), .reset_n(reset_n), .flush(~portEnable), .limit(limit),
    .push(txPush), .pushData(wData[W-1:0]), .pop(shLoad), .headData(txHead),
    .count(txCount), .full(txFull), .empty(txEmpty)
  );

  ssc_fifo #(.W(W), .DEPTH(DEPTH)) u_rx (
    .ref_clk(ref_clk), .reset_n(reset_n), .flush(~portEnable), .limit(limit),
    .push(rxPush), .pushData(rxWord), .pop(rxPop), .headData(rxHead),
    .count(rxCount), .full(rxFull), .empty(rxEmpty)
  );

  // serial shift engine
  ssc_shifter #(.W(W), .HALF(HALF)) u_sh (
    .ref_clk(ref_clk), .reset_n(reset_n), .run(run), .master(master),
    .load(shLoad), .loadData(txHead), .busy(shBusy), .rxDone(rxDone),
    .sent(shSent), .rxData(rxWord), .serialClockIn(serialClockIn),
    .serialIn(serialIn), .slaveSelectIn(slaveSelectIn),
    .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
    .serialOut(serialOut), .serialOutOe(serialOutOe),
    .slaveSelectOut(slaveSelectOut), .slaveSelectOe(slaveSelectOe)
  );

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {s_axi_awready, s_axi_wready} <= 2'h3;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      {awAddr, wData, wStrb} <= '0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr        <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (arHs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control fields, byte lanes honoured
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {portEnable, idleStop, enh, master} <= 4'h0;
      interrupt_condition_select <= INTERRUPT_CONDITION_SELECT_RST;
      irqEn <= IRQ_EN_RST;
    end else begin
      if (wrStat & wStrb[1]) begin
        portEnable <= wData[BIT_EN];
        idleStop   <= wData[BIT_SIDL];
      end
      if (wrStat & wStrb[0]) interrupt_condition_select <= wData[BIT_INTERRUPT_CONDITION_SELECT+:3];
      if (wrCtrl & wStrb[0]) {master, enh} <= {wData[BIT_MSTR], wData[BIT_ENH]};
      if (wrIrqEn & wStrb[0]) irqEn <= wData[1:0];
    end
  end

  // sticky flags, a set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rov     <= 1'b0;
      irqStat <= 2'h0;
      irq     <= 1'b0;
      {loadD, readD, txFullD} <= 3'h0;
    end else begin
      rov     <= rxOver | (rov & ~rovClr);
      irqStat <= irqSet | (irqStat & ~irqClr);
      irq     <= |(irqStat & irqEn);
      loadD   <= shLoad;
      readD   <= rxPop;
      txFullD <= txFull;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_DISABLE_HALTS: assert property (!portEnable |=> !shBusy && txEmpty)
    else $error("disabled port still busy");
  AST_IDLE_STOP: assert property (idleStop && deviceIdle |=> !shBusy)
    else $error("shifter ran in idle with idle stop");
  AST_BEC_MASTER: assert property (enh && master && txCount < 7 |-> statRd[10:8] == txCount[2:0])
    else $error("element count wrong");
  AST_SR_EMPTY: assert property (shLoad |=> !statRd[BIT_SHIFT_REG_EMPTY_FLAG] ##0 shBusy)
    else $error("shift empty flag after load");
  AST_OVERFLOW: assert property (rxDone && rxFull && !rxPop |=> rov && rxCount == $past(rxCount))
    else $error("overflow not flagged or word kept");
  AST_RX_EMPTY: assert property (rxPush && !rxPop |=> !statRd[BIT_RX_FIFO_EMPTY_FLAG])
    else $error("receive empty flag after push");
  AST_IRQ_TXFULL: assert property (enh && interrupt_condition_select == SIS_TXFULL && txFull && !txFullD |=> irqStat[IRQ_COND])
    else $error("tx full interrupt missing");
  AST_IRQ_SENT: assert property (enh && interrupt_condition_select == SIS_SENT && shSent |=> irqStat[IRQ_COND])
    else $error("sent interrupt missing");
  AST_IRQ_RX3Q: assert property (enh && interrupt_condition_select == SIS_RX3Q && rxCount >= 6 |=> irqStat[IRQ_COND])
    else $error("three quarter interrupt missing");
  AST_IRQ_READ: assert property (enh && interrupt_condition_select == SIS_RXREAD && rxPop && rxCount == 1 && !rxPush
    |-> ##2 irqStat[IRQ_COND])
    else $error("read empty interrupt missing");
  AST_TBF_STD: assert property (!enh && txPush |=> txFull ##1 1)
    else $error("standard tx full not set");
  AST_TBF_ENH: assert property (enh && txFull && shLoad && !txPush |=> !txFull)
    else $error("enhanced tx full not cleared");
  AST_RBF_STD: assert property (!enh && rxPop && !rxPush |=> !rxFull)
    else $error("standard rx full not cleared by read");
  AST_RBF_ENH: assert property (enh && rxPush && !rxPop && rxCount == CW'(DEPTH - 1) |=> rxFull)
    else $error("enhanced rx full not set");
  AST_DEPTH: assert property (txCount <= CW'(DEPTH) && rxCount <= CW'(DEPTH))
    else $error("store count beyond depth");

  COV_FRAME: cover property (shLoad ##[1:200] shSent);
  COV_OVER: cover property (rxOver);
  COV_TXFULL_ENH: cover property (enh && txFull);
  COV_IRQ: cover property (irq);

endmodule

// [tb/ssc_peer_model.sv]
// ssc_peer_model: far-side serial slave, mode 0, msb first
// assumes: the block is serial master; replyWord is stable during a frame
`timescale 1ns/1ps
module ssc_peer_model (
  // pins from the block
  input  wire logic       serialClockOut,
  input  wire logic       slaveSelectOut,
  input  wire logic       serialOut,
  // pin toward the block
  output logic            serialIn,
  // word returned and word caught
  input  wire logic [7:0] replyWord,
  output logic      [7:0] caughtWord
);
  int bitIdx;
  initial begin
    serialIn = 1'b0;
    bitIdx = 0;
    caughtWord = 8'h00;
  end
  // frame start: present the msb
  always @(negedge slaveSelectOut) begin
    bitIdx = 7;
    serialIn = replyWord[7];
  end
  // catch on rising, move on falling
  always @(posedge serialClockOut) if (!slaveSelectOut) caughtWord = {caughtWord[6:0], serialOut};
  always @(negedge serialClockOut) if (!slaveSelectOut && bitIdx > 0) begin
    bitIdx--;
    serialIn = replyWord[bitIdx];
  end
  // released line shows no stale bit
  always @(posedge slaveSelectOut) serialIn = ~serialIn;
endmodule

// [tb/ssc_top_tb.sv]
// ssc_top_tb: register bus and serial checks of the status block
// assumes: block is master toward ssc_peer_model; select and clock inputs idle
`timescale 1ns/1ps
module ssc_top_tb import ssc_pkg::*;;
  logic ref_clk = 0, reset_n = 0, deviceIdle = 0, serialClockIn = 0, slaveSelectIn = 1, serialIn;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rep = 0, caught;
  logic [31:0] s_axi_wdata = 0, d, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, serialClockOut;
  logic serialClockOe, serialOut, serialOutOe, slaveSelectOut, slaveSelectOe;
  int errors = 0, n_checks = 0;
  ssc_top uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .deviceIdle(deviceIdle),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq),
    .serialClockIn(serialClockIn), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutOe(serialOutOe),
    .slaveSelectIn(slaveSelectIn), .slaveSelectOut(slaveSelectOut), .slaveSelectOe(slaveSelectOe)
  );
  ssc_peer_model peer (.serialClockOut(serialClockOut), .slaveSelectOut(slaveSelectOut),
    .serialOut(serialOut), .serialIn(serialIn), .replyWord(rep), .caughtWord(caught));
  initial forever #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 99) begin
      errors++;
      summarize();
    end
  endtask
  // write: address and data together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ta, tw, tb;
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    n = 0;
    do begin
      @(negedge ref_clk);
      ta = s_axi_awvalid & s_axi_awready; tw = s_axi_wvalid & s_axi_wready; tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) s_axi_bready <= 0;
      n++;
    end while (!tb && n < 99);
    // one edge between transfers, no double drive of bready
    @(posedge ref_clk);
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, tr;
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    n = 0;
    do begin
      @(negedge ref_clk);
      ta = s_axi_arvalid & s_axi_arready; tr = s_axi_rvalid; d = s_axi_rdata; rs = s_axi_rresp;
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 0;
      if (tr) s_axi_rready <= 0;
      n++;
    end while (!tr && n < 99);
    // one edge between transfers, no double drive of rready
    @(posedge ref_clk);
    tmo(n);
  endtask
  // one whole frame: select seen low, then high again
  task automatic frame();
    int n;
    bit s;
    s = 0;
    for (n = 0; n < 99 && !(s && slaveSelectOut); n++) repeat (3) @(negedge ref_clk) s |= !slaveSelectOut;
    // hand back on a rising edge so the next stimulus is launched there
    @(posedge ref_clk);
    tmo(n);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_standard();
    wr(OFF_CTRL, 32'h2); wr(OFF_STAT, 32'h8004); wr(OFF_IRQ_EN, 32'h1);
    chk({serialClockOe, slaveSelectOe, serialOutOe}, 32'h7);
    rep <= 8'h3c; wr(OFF_DATA, 32'ha5); frame();
    chk(caught, 8'ha5);
    rd(OFF_STAT); chk(d & 32'h8047, 32'h8005);
    chk(irq, 1);
    rd(OFF_DATA); chk(d, 32'h3c);
    rd(OFF_STAT); chk(d & 32'h3, 32'h0);
    wr(OFF_IRQ_CLR, 32'h3); repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    rep <= 8'h11; wr(OFF_DATA, 32'h01); frame();
    rep <= 8'h22; wr(OFF_DATA, 32'h02); frame();
    rd(OFF_STAT); chk(d & 32'h41, 32'h41);
    rd(OFF_DATA); chk(d, 32'h11);
    wr(OFF_STAT, 32'h8004); rd(OFF_STAT); chk(d & 32'h40, 32'h0);
  endtask
  task automatic t_idle_disable();
    deviceIdle <= 1; wr(OFF_STAT, 32'ha000); wr(OFF_DATA, 32'h77);
    repeat (40) @(posedge ref_clk);
    chk(slaveSelectOut, 1);
    deviceIdle <= 0;
    frame();
    rd(OFF_DATA);
    chk(d, 32'h22);
    wr(OFF_STAT, 32'h0);
    chk({serialClockOe, slaveSelectOe, serialOutOe}, 32'h0);
  endtask
  task automatic t_enhanced();
    int n;
    wr(OFF_CTRL, 32'h3); wr(OFF_STAT, 32'h801c); wr(OFF_IRQ_CLR, 32'h3); rep <= 8'h5a;
    for (n = 0; n < 9; n++) wr(OFF_DATA, n);
    rd(OFF_STAT); chk(d & 32'h0702, 32'h0702);
    chk(irq, 1);
    n = 0;
    do begin
      repeat (8) @(posedge ref_clk);
      rd(OFF_STAT); n++;
    end while ((d & 32'h782) != 32'h80 && n < 99);
    tmo(n);
    rd(OFF_STAT); chk(d & 32'h61, 32'h41);
    for (n = 0; n < 8; n++) begin
      rd(OFF_DATA); chk(d, 32'h5a);
    end
    rd(OFF_STAT); chk(d & 32'h21, 32'h20);
    // select 101: interrupt only once the last bit has left
    wr(OFF_STAT, 32'h8014);
    wr(OFF_IRQ_CLR, 32'h3);
    wr(OFF_DATA, 32'h3c);
    chk(irq, 0);
    frame();
    repeat (2) @(posedge ref_clk);
    chk(irq, 1);
    // select 000: interrupt when reading empties the receive store
    wr(OFF_STAT, 32'h8000);
    wr(OFF_IRQ_CLR, 32'h3);
    chk(irq, 0);
    rd(OFF_DATA);
    chk(d, 32'h5a);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    rd(OFF_IRQ_EN); chk(d, {30'h0, IRQ_EN_RST});
    rd(8'h40);
    chk({rs, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h40, 32'h0);
    chk(32'(rs), 32'(RESP_SLVERR));
    t_standard();
    t_idle_disable();
    t_enhanced();
    summarize();
  end
endmodule
